// *** logic/sclcr_top.sv ***
// Purpose: serial-accessed loop config registers for two channels
// Assumes: serial clock well below mclk/8, mode 0, MSB first
// Notes: a frame's answer goes out in the following frame
//
// Notes on behaviour
// RULE_01 - frame bit 31 high writes, low reads; read-back bit 31 is 0
// RULE_02 - upper clamp field, 12 bits at 23:12, resets to 7FF per channel
// RULE_03 - integrator upper bound is thirty-two times the upper field
// RULE_04 - lower clamp field, 12 bits at 11:0, resets to 7FF per channel
// RULE_05 - integrator lower bound is minus thirty-two times the lower field
// RULE_06 - gain shift at 22:20 sets period integral gain to 2^-shift
// RULE_07 - gain shift saturates at 6; writing 7 stores 6
// RULE_08 - gain shift resets to 2, a gain of one quarter
// RULE_09 - threshold reads at 21:6, zero after reset, host writes ignored
// RULE_10 - stage turns off when the integrator reaches the threshold
// RULE_11 - period controller alone computes and updates the threshold
// RULE_12 - open-load limit, 6 bits at 5:0, resets 0, lsb 1500/255 mA
// RULE_13 - open-load-while-on detection runs only with nonzero limit
// RULE_14 - channel bits 25:24: 01 first output, 10 second, others none
// RULE_15 - bits 30:27 select: 4 clamps, 5 period, 6 threshold/open-load
// RULE_16 - switching period, 12 bits at 11:0, lsb sixteen mclk periods
`timescale 1ns/1ps
`default_nettype none
`include "sclcr_consts.svh"
module sclcr_top (
	input  wire logic                        mclk,
	input  wire logic                        reset_n,
	input  wire logic                        spiClk,
	input  wire logic                        spiSelN,
	input  wire logic                        spiDataIn,
	output logic                             spiDataOut,
	output logic                             spiDataOutEn,
	input  wire sclcr_pkg::sclcr_meas_s [1:0] chMeas,
	output logic [1:0]                       stageOn,
	output logic [1:0]                       olFault
);

	// ****************************************
	// declarations
	// ****************************************
	sclcr_pkg::sclcr_state_e state_r;
	sclcr_pkg::sclcr_cfg_s   cfg_r [0:1];
	logic [15:0]             thrVal [0:1];
	logic [2:0]              pinSync;
	logic                    clkS;
	logic                    selS;
	logic                    dinS;
	logic                    clkD_r;
	logic                    rise;
	logic                    fall;
	logic [5:0]              bitCnt_r;
	logic [31:0]             rx_r;
	logic [31:0]             tx_r;
	logic [31:0]             resp_r;
	logic [31:0]             word_r;
	logic                    frameStb_r;
	logic                    respLoad_r;
	logic [3:0]              tickCnt_r;
	logic                    tick;
	logic [1:0]              chCode;
	logic                    chOk;
	logic                    chIdx;
	logic                    doWrite;

	function automatic logic [2:0] satGain(input logic [2:0] g);
		return (g > `SCLCR_GAIN_MAX) ? `SCLCR_GAIN_MAX : g;
	endfunction

	function automatic logic [31:0] readWord(
		input logic [31:0]           w,
		input sclcr_pkg::sclcr_cfg_s c,
		input logic [15:0]           t,
		input logic                  ok);
		logic [31:0] r;
		r = {1'h0, w[`SCLCR_SEL_HI:`SCLCR_SEL_LO], 1'h0,
			w[`SCLCR_CH_HI:`SCLCR_CH_LO], 24'h000000}; // see RULE_01
		if (ok) begin
			case (w[`SCLCR_SEL_HI:`SCLCR_SEL_LO]) // see RULE_15
				sclcr_pkg::SCLCR_SEL_CLAMP: begin
					r[`SCLCR_HI_MSB:`SCLCR_HI_LSB] = c.hiClamp;
					r[`SCLCR_LO_MSB:`SCLCR_LO_LSB] = c.loClamp;
				end
				sclcr_pkg::SCLCR_SEL_PERIOD: begin
					r[`SCLCR_GAIN_MSB:`SCLCR_GAIN_LSB] = c.gainShift;
					r[`SCLCR_PER_MSB:`SCLCR_PER_LSB] = c.period;
				end
				sclcr_pkg::SCLCR_SEL_THRESH: begin
					r[`SCLCR_THR_MSB:`SCLCR_THR_LSB] = t; // see RULE_09
					r[`SCLCR_OL_MSB:`SCLCR_OL_LSB] = c.olLimit;
				end
				default: begin
				end
			endcase
		end
		return r;
	endfunction

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	sclcr_sync #(
		.W   (3),
		.RST (3'h2)
	) u_sync (
		.mclk                    (mclk),
		.reset_n                 (reset_n),
		.pinIn                   ({spiClk, spiSelN, spiDataIn}),
		.pinSync                 (pinSync)
	);

	assign clkS = pinSync[2];
	assign selS = pinSync[1];
	assign dinS = pinSync[0];

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			clkD_r <= 1'h0;
		end else begin
			clkD_r <= clkS;
		end
	end

	assign rise = clkS && !clkD_r;
	assign fall = !clkS && clkD_r;

	// ****************************************
	// frame receiver
	// ****************************************
	// a short or long frame is dropped whole, never half applied
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_r <= sclcr_pkg::SCLCR_IDLE;
			bitCnt_r <= '0;
			rx_r <= '0;
		end else begin
			unique case (state_r)
				sclcr_pkg::SCLCR_IDLE: begin
					bitCnt_r <= '0;
					if (!selS) begin
						state_r <= sclcr_pkg::SCLCR_SHIFT;
					end
				end
				sclcr_pkg::SCLCR_SHIFT: begin
					if (selS) begin
						state_r <= sclcr_pkg::SCLCR_IDLE;
					end else if (rise && bitCnt_r != 6'h3F) begin
						rx_r <= {rx_r[30:0], dinS};
						bitCnt_r <= bitCnt_r + 6'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			frameStb_r <= 1'h0;
			word_r <= '0;
		end else begin
			frameStb_r <= state_r == sclcr_pkg::SCLCR_SHIFT && selS
				&& bitCnt_r == 6'(`SCLCR_FRAME_BITS);
			if (state_r == sclcr_pkg::SCLCR_SHIFT && selS) begin
				word_r <= rx_r;
			end
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tx_r <= '0;
		end else if (state_r == sclcr_pkg::SCLCR_IDLE) begin
			tx_r <= resp_r;
		end else if (fall && bitCnt_r != 6'h00) begin
			tx_r <= {tx_r[30:0], 1'h0};
		end
	end

	assign spiDataOut = tx_r[31];
	assign spiDataOutEn = state_r == sclcr_pkg::SCLCR_SHIFT;

	// ****************************************
	// decode and register file
	// ****************************************
	assign chCode = word_r[`SCLCR_CH_HI:`SCLCR_CH_LO];
	assign chOk = chCode == `SCLCR_CH_ONE
		|| chCode == `SCLCR_CH_TWO; // see RULE_14
	assign chIdx = chCode == `SCLCR_CH_TWO;
	assign doWrite = frameStb_r && word_r[`SCLCR_RW_BIT] && chOk; // see RULE_01

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			for (int i = 0; i < 2; i++) begin
				cfg_r[i].hiClamp <= `SCLCR_CLAMP_RST; // see RULE_02
				cfg_r[i].loClamp <= `SCLCR_CLAMP_RST; // see RULE_04
				cfg_r[i].gainShift <= `SCLCR_GAIN_RST; // see RULE_08
				cfg_r[i].period <= `SCLCR_PER_RST;
				cfg_r[i].olLimit <= `SCLCR_OL_RST;
			end
		end else if (doWrite) begin
			case (word_r[`SCLCR_SEL_HI:`SCLCR_SEL_LO]) // see RULE_15
				sclcr_pkg::SCLCR_SEL_CLAMP: begin
					cfg_r[chIdx].hiClamp <=
						word_r[`SCLCR_HI_MSB:`SCLCR_HI_LSB]; // see RULE_02
					cfg_r[chIdx].loClamp <=
						word_r[`SCLCR_LO_MSB:`SCLCR_LO_LSB]; // see RULE_04
				end
				sclcr_pkg::SCLCR_SEL_PERIOD: begin
					cfg_r[chIdx].gainShift <= satGain(
						word_r[`SCLCR_GAIN_MSB:`SCLCR_GAIN_LSB]); // see RULE_07
					cfg_r[chIdx].period <=
						word_r[`SCLCR_PER_MSB:`SCLCR_PER_LSB]; // see RULE_16
				end
				sclcr_pkg::SCLCR_SEL_THRESH: begin
					// threshold bits in the frame are dropped here
					cfg_r[chIdx].olLimit <=
						word_r[`SCLCR_OL_MSB:`SCLCR_OL_LSB]; // see RULE_12
				end
				default: begin
				end
			endcase
		end
	end

	// answer is taken after the write so it shows the new value
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			respLoad_r <= 1'h0;
			resp_r <= '0;
		end else begin
			respLoad_r <= frameStb_r;
			if (respLoad_r) begin
				resp_r <= readWord(word_r, cfg_r[chIdx],
					thrVal[chIdx], chOk);
			end
		end
	end

	// ****************************************
	// period tick and channels
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tickCnt_r <= '0;
		end else begin
			tickCnt_r <= tickCnt_r + 4'h1;
		end
	end

	assign tick = tickCnt_r == 4'(`SCLCR_TICK_CLKS - 1); // see RULE_16

	for (genvar g = 0; g < 2; g++) begin : g_chan
		sclcr_chan u_chan (
			.mclk    (mclk),
			.reset_n (reset_n),
			.tick    (tick),
			.cfg     (cfg_r[g]),
			.meas    (chMeas[g]),
			.thrVal  (thrVal[g]),
			.stageOn (stageOn[g]),
			.olFault (olFault[g])
		);
	end

	// ****************************************
	// checks
	// ****************************************
	a_rw_readback: assert property ( // see RULE_01
		@(posedge mclk) disable iff (!reset_n)
		respLoad_r |=> !resp_r[31])
		else $error("read-back bit 31 not zero");
	a_gain_sat: assert property ( // see RULE_07
		@(posedge mclk) disable iff (!reset_n)
		doWrite && word_r[30:27] == 4'h5 && word_r[22:20] == 3'h7
		|=> cfg_r[$past(chIdx)].gainShift == 3'h6)
		else $error("gain shift not saturated to 6");
	a_gain_reset: assert property ( // see RULE_08
		@(posedge mclk)
		$rose(reset_n) |-> cfg_r[0].gainShift == 3'h2
		&& cfg_r[1].gainShift == 3'h2)
		else $error("gain shift reset value wrong");
	a_clamp_write: assert property ( // see RULE_02
		@(posedge mclk) disable iff (!reset_n)
		doWrite && word_r[30:27] == 4'h4
		|=> {cfg_r[$past(chIdx)].hiClamp, cfg_r[$past(chIdx)].loClamp}
		== $past(word_r[23:0]))
		else $error("clamp write not stored");
	a_clamp_reset: assert property ( // see RULE_04
		@(posedge mclk)
		$rose(reset_n) |-> cfg_r[1].loClamp == 12'h7FF
		&& cfg_r[1].hiClamp == 12'h7FF
		&& cfg_r[0].loClamp == 12'h7FF && cfg_r[0].hiClamp == 12'h7FF)
		else $error("clamp reset value wrong");
	a_nochan_ignored: assert property ( // see RULE_14
		@(posedge mclk) disable iff (!reset_n)
		frameStb_r && !chOk |=> $stable(cfg_r[0]) && $stable(cfg_r[1]))
		else $error("write with no channel changed settings");
	a_thr_readback: assert property ( // see RULE_09
		@(posedge mclk) disable iff (!reset_n)
		respLoad_r && chOk && word_r[30:27] == 4'h6
		|=> resp_r[21:6] == $past(thrVal[chIdx]))
		else $error("threshold read-back mismatch");
	a_tick_spacing: assert property ( // see RULE_16
		@(posedge mclk) disable iff (!reset_n)
		tick |=> !tick [*8] ##1 !tick [*7] ##1 tick)
		else $error("period tick not every sixteen clocks");
	a_ol_write: assert property ( // see RULE_12
		@(posedge mclk) disable iff (!reset_n)
		doWrite && word_r[30:27] == 4'h6
		|=> cfg_r[$past(chIdx)].olLimit == $past(word_r[5:0]))
		else $error("open-load limit write not stored");

endmodule // sclcr_top
`default_nettype wire

// *** logic/sclcr_consts.svh ***
// Purpose: offsets, field positions, resets and timing counts
// Assumes: 32-bit serial frame, 20 MHz mclk
// Notes: definitions only
`ifndef SCLCR_CONSTS_SVH
`define SCLCR_CONSTS_SVH

// ****************************************
// frame layout
// ****************************************
`define SCLCR_FRAME_BITS 32
`define SCLCR_RW_BIT     31
`define SCLCR_SEL_HI     30
`define SCLCR_SEL_LO     27
`define SCLCR_CH_HI      25
`define SCLCR_CH_LO      24
`define SCLCR_CH_ONE     2'h1
`define SCLCR_CH_TWO     2'h2

// ****************************************
// field positions
// ****************************************
`define SCLCR_HI_MSB     23
`define SCLCR_HI_LSB     12
`define SCLCR_LO_MSB     11
`define SCLCR_LO_LSB     0
`define SCLCR_GAIN_MSB   22
`define SCLCR_GAIN_LSB   20
`define SCLCR_PER_MSB    11
`define SCLCR_PER_LSB    0
`define SCLCR_THR_MSB    21
`define SCLCR_THR_LSB    6
`define SCLCR_OL_MSB     5
`define SCLCR_OL_LSB     0

// ****************************************
// reset values and scaling
// ****************************************
`define SCLCR_CLAMP_RST  12'h7FF
`define SCLCR_GAIN_RST   3'h2
`define SCLCR_GAIN_MAX   3'h6
`define SCLCR_PER_RST    12'h000
`define SCLCR_OL_RST     6'h00
`define SCLCR_THR_RST    16'h0000
`define SCLCR_CLAMP_SCALE 32

// ****************************************
// timing
// ****************************************
`define SCLCR_CLK_NS     50
`define SCLCR_TICK_CLKS  16

`endif

// *** logic/sclcr_pkg.sv ***
// Purpose: types for the solenoid loop config registers
// Assumes: constants live in sclcr_consts.svh
// Notes: none
`default_nettype none
package sclcr_pkg;

	// ****************************************
	// register select codes and receiver states
	// ****************************************
	typedef enum logic [3:0] {
		SCLCR_SEL_CLAMP  = 4'h4,
		SCLCR_SEL_PERIOD = 4'h5,
		SCLCR_SEL_THRESH = 4'h6
	} sclcr_sel_e;

	typedef enum logic [0:0] {
		SCLCR_IDLE  = 1'h0,
		SCLCR_SHIFT = 1'h1
	} sclcr_state_e;

	// ****************************************
	// per-channel settings and loop inputs
	// ****************************************
	typedef struct packed {
		logic [11:0] hiClamp;
		logic [11:0] loClamp;
		logic [2:0]  gainShift;
		logic [11:0] period;
		logic [5:0]  olLimit;
	} sclcr_cfg_s;

	typedef struct packed {
		logic               errStb;
		logic signed [15:0] err;
		logic               cycleEnd;
		logic [7:0]         curSample;
	} sclcr_meas_s;

endpackage
`default_nettype wire

// *** logic/sclcr_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: pins are asynchronous to mclk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sclcr_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinSync
);
	logic [W-1:0] stage1_r;
	logic [W-1:0] stage2_r;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			stage1_r <= RST;
			stage2_r <= RST;
		end else begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
		end
	end

	assign pinSync = stage2_r;
endmodule // sclcr_sync
`default_nettype wire

// *** logic/sclcr_chan.sv ***
// Purpose: one channel's integrator, period controller, open-load check
// Assumes: loop inputs come from logic on mclk
// Notes: threshold is owned here, never written by the host
`timescale 1ns/1ps
`default_nettype none
`include "sclcr_consts.svh"
module sclcr_chan (
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	input  wire logic                   tick,
	input  wire sclcr_pkg::sclcr_cfg_s  cfg,
	input  wire sclcr_pkg::sclcr_meas_s meas,
	output logic [15:0]                 thrVal,
	output logic                        stageOn,
	output logic                        olFault
);
	logic signed [19:0] integ_r;
	logic signed [19:0] upper;
	logic signed [19:0] lower;
	logic signed [19:0] sum;
	logic signed [13:0] diff;
	logic signed [13:0] step;
	logic signed [17:0] thrSum;
	logic [15:0]        thr_r;
	logic [11:0]        perCnt_r;
	logic               stage_r;
	logic               ol_r;
	logic               reached;

	function automatic logic signed [19:0] clampBound(
		input logic [11:0] f);
		return 20'(32'(f) * `SCLCR_CLAMP_SCALE);
	endfunction

	// ****************************************
	// integrator with clamps
	// ****************************************
	assign upper = clampBound(cfg.hiClamp); // see RULE_03
	assign lower = -clampBound(cfg.loClamp); // see RULE_05
	assign sum = integ_r + 20'(signed'(meas.err));
	assign reached = integ_r >= signed'({4'h0, thr_r});

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			integ_r <= '0;
		end else if (meas.cycleEnd) begin
			integ_r <= '0;
		end else if (meas.errStb && stage_r) begin
			if (sum > upper) begin
				integ_r <= upper; // see RULE_03
			end else if (sum < lower) begin
				integ_r <= lower; // see RULE_05
			end else begin
				integ_r <= sum;
			end
		end
	end

	// output stage drops once the integrator meets the threshold
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			stage_r <= 1'h0;
		end else if (meas.cycleEnd) begin
			stage_r <= 1'h1;
		end else if (stage_r && reached) begin
			stage_r <= 1'h0; // see RULE_10
		end
	end

	// ****************************************
	// period controller
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!reset_n || meas.cycleEnd) begin
			perCnt_r <= '0;
		end else if (tick && perCnt_r != 12'hFFF) begin
			perCnt_r <= perCnt_r + 12'h001;
		end
	end

	// gain as a shift: coarse, but no multiplier needed
	assign diff = signed'({2'h0, cfg.period}) - signed'({2'h0, perCnt_r});
	assign step = diff >>> cfg.gainShift; // see RULE_06
	assign thrSum = signed'({2'h0, thr_r}) + 18'(step);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			thr_r <= `SCLCR_THR_RST;
		end else if (meas.cycleEnd) begin
			if (thrSum < 18'sh00000) begin
				thr_r <= 16'h0000; // see RULE_11
			end else if (thrSum > 18'sh0FFFF) begin
				thr_r <= 16'hFFFF;
			end else begin
				thr_r <= thrSum[15:0]; // see RULE_11
			end
		end
	end

	// ****************************************
	// open load while on
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ol_r <= 1'h0;
		end else begin
			ol_r <= stage_r && cfg.olLimit != 6'h00
				&& meas.curSample < {2'h0, cfg.olLimit}; // see RULE_13
		end
	end

	assign thrVal = thr_r;
	assign stageOn = stage_r;
	assign olFault = ol_r;

	a_upper_hold: assert property ( // see RULE_03
		@(posedge mclk) disable iff (!reset_n)
		meas.errStb && stage_r && !meas.cycleEnd
		|=> integ_r <= $past(upper))
		else $error("integrator above upper clamp");
	a_lower_hold: assert property ( // see RULE_05
		@(posedge mclk) disable iff (!reset_n)
		meas.errStb && stage_r && !meas.cycleEnd
		|=> integ_r >= $past(lower))
		else $error("integrator below lower clamp");
	a_thr_owned: assert property ( // see RULE_11
		@(posedge mclk) disable iff (!reset_n)
		!meas.cycleEnd |=> $stable(thr_r))
		else $error("threshold moved outside cycle end");
	a_stage_off: assert property ( // see RULE_10
		@(posedge mclk) disable iff (!reset_n)
		stage_r && reached && !meas.cycleEnd |=> !stage_r)
		else $error("stage stayed on past threshold");
	a_ol_gate: assert property ( // see RULE_13
		@(posedge mclk) disable iff (!reset_n)
		cfg.olLimit == 6'h00 |=> !ol_r)
		else $error("open-load fault with zero limit");
endmodule // sclcr_chan
`default_nettype wire

// *** tb/sclcr_host.sv ***
// Purpose: host serial master model for the loop config registers
// Assumes: mode 0, MSB first, 32-bit frames, mclk 20 MHz
// Notes: every half period of the serial clock is 8 mclk
`timescale 1ns/1ps
`default_nettype none
module sclcr_host (
	input  wire logic mclk,
	output logic      spiClk,
	output logic      spiSelN,
	output logic      spiDataIn,
	input  wire logic spiDataOut
);
	// ****************************************
	// idle levels
	// ****************************************
	initial begin
		spiClk <= 1'b0;
		spiSelN <= 1'b1;
		spiDataIn <= 1'b0;
	end

	// ****************************************
	// frame building and transfer
	// ****************************************
	function automatic logic [31:0] frame(input logic rw,
		input logic [3:0] sel, input logic [1:0] ch, input logic [23:0] d);
		return {rw, sel, 1'b0, ch, d};
	endfunction

	// halves of 8 mclk keep well above the 4 mclk minimum
	task automatic xfer(input logic [31:0] w, input int nBits,
		output logic [31:0] r);
		r = '0;
		@(posedge mclk);
		spiSelN <= 1'b0;
		for (int i = 0; i < nBits; i++) begin
			spiDataIn <= w[31-i];
			repeat (8) @(posedge mclk);
			spiClk <= 1'b1;
			r = {r[30:0], spiDataOut};
			repeat (8) @(posedge mclk);
			spiClk <= 1'b0;
		end
		repeat (8) @(posedge mclk);
		spiSelN <= 1'b1;
		// released data line must not keep its last level
		spiDataIn <= ~spiDataIn;
		repeat (16) @(posedge mclk);
	endtask
endmodule // sclcr_host
`default_nettype wire

// *** tb/solenoid_current_loop_config_regs_test.sv ***
// Purpose: self-checking bench for the loop config registers
// Assumes: host model drives the serial pins, bench drives chMeas
// Notes: a read's answer arrives in the following frame
`timescale 1ns/1ps
`default_nettype none
module solenoid_current_loop_config_regs_test;
	typedef struct packed {
		logic [3:0]  sel;
		logic [1:0]  wch;
		logic [23:0] wd;
		logic [1:0]  rch;
		logic [23:0] ed;
	} sclcr_row_s;

	logic                         mclk;
	logic                         reset_n;
	wire logic                    spiClk;
	wire logic                    spiSelN;
	wire logic                    spiDataIn;
	wire logic                    spiDataOut;
	wire logic                    spiDataOutEn;
	sclcr_pkg::sclcr_meas_s [1:0] chMeas;
	wire logic [1:0]              stageOn;
	wire logic [1:0]              olFault;
	int                           miscompares;
	int                           num_checks;
	logic [31:0]                  r;

	// ****************************************
	// ordinary cases: write, then read back
	// ****************************************
	localparam sclcr_row_s ROWS [7] = '{
		'{4'h4, 2'h1, 24'h123456, 2'h1, 24'h123456},
		'{4'h4, 2'h2, 24'hFFF000, 2'h2, 24'hFFF000},
		'{4'h4, 2'h3, 24'h000000, 2'h1, 24'h123456},
		'{4'h5, 2'h1, 24'h700ABC, 2'h1, 24'h600ABC},
		'{4'h5, 2'h2, 24'h000001, 2'h2, 24'h000001},
		'{4'h6, 2'h1, 24'hFFFFFF, 2'h1, 24'h00003F},
		'{4'h6, 2'h0, 24'h00002A, 2'h0, 24'h000000}
	};

	sclcr_top sclcr_top_inst (
		.mclk(mclk),
		.reset_n(reset_n),
		.spiClk(spiClk),
		.spiSelN(spiSelN),
		.spiDataIn(spiDataIn),
		.spiDataOut(spiDataOut),
		.spiDataOutEn(spiDataOutEn),
		.chMeas(chMeas),
		.stageOn(stageOn),
		.olFault(olFault)
	);

	sclcr_host sclcr_host_inst (
		.mclk(mclk),
		.spiClk(spiClk),
		.spiSelN(spiSelN),
		.spiDataIn(spiDataIn),
		.spiDataOut(spiDataOut)
	);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// two frames: the second carries the first one's answer
	task automatic readReg(input logic [3:0] sel, input logic [1:0] ch,
		output logic [31:0] rr);
		logic [31:0] w;
		w = sclcr_host_inst.frame(1'b0, sel, ch, 24'h000000);
		sclcr_host_inst.xfer(w, 32, rr);
		sclcr_host_inst.xfer(w, 32, rr);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (80000) @(posedge mclk);
		miscompares++;
		summarize();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		miscompares = 0;
		num_checks = 0;
		reset_n <= 1'b0;
		chMeas <= '0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		for (int i = 0; i < 7; i++) begin
			sclcr_host_inst.xfer(sclcr_host_inst.frame(1'b1, ROWS[i].sel,
				ROWS[i].wch, ROWS[i].wd), 32, r);
			readReg(ROWS[i].sel, ROWS[i].rch, r);
			check(r, sclcr_host_inst.frame(1'b0, ROWS[i].sel,
				ROWS[i].rch, ROWS[i].ed));
			$display("row %0d done", i);
		end
		check({31'h0, spiDataOutEn}, 32'h0);

		// short frame must leave the clamps untouched
		fork
			sclcr_host_inst.xfer(sclcr_host_inst.frame(1'b1, 4'h4, 2'h1,
				24'h000000), 31, r);
			begin
				repeat (100) @(posedge mclk);
				check({31'h0, spiDataOutEn}, 32'h1);
			end
		join
		readReg(4'h4, 2'h1, r);
		check(r, 32'h21123456);
		$display("short frame done");

		// loop on the second channel, open-load limit still zero
		sclcr_host_inst.xfer(sclcr_host_inst.frame(1'b1, 4'h5, 2'h2,
			24'h000FFF), 32, r);
		repeat (2) begin
			@(posedge mclk);
			chMeas[1].cycleEnd <= 1'b1;
			@(posedge mclk);
			chMeas[1].cycleEnd <= 1'b0;
			repeat (3) @(posedge mclk);
		end
		check({31'h0, stageOn[1]}, 32'h1);
		readReg(4'h6, 2'h2, r);
		check({31'h0, r[21:6] === 16'h0000}, 32'h0);
		check({31'h0, olFault[1]}, 32'h0);
		@(posedge mclk);
		chMeas[1].err <= 16'sh7FFF;
		chMeas[1].errStb <= 1'b1;
		@(posedge mclk);
		chMeas[1].errStb <= 1'b0;
		repeat (4) @(posedge mclk);
		check({31'h0, stageOn[1]}, 32'h0);
		$display("loop test done");

		// tight clamps hold the integrator under the threshold
		sclcr_host_inst.xfer(sclcr_host_inst.frame(1'b1, 4'h4, 2'h2,
			24'h001001), 32, r);
		sclcr_host_inst.xfer(sclcr_host_inst.frame(1'b1, 4'h6, 2'h2,
			24'h000010), 32, r);
		@(posedge mclk);
		chMeas[1].cycleEnd <= 1'b1;
		@(posedge mclk);
		chMeas[1].cycleEnd <= 1'b0;
		chMeas[1].errStb <= 1'b1;
		@(posedge mclk);
		chMeas[1].errStb <= 1'b0;
		repeat (4) @(posedge mclk);
		check({31'h0, stageOn[1]}, 32'h1);
		check({31'h0, olFault[1]}, 32'h1);
		$display("clamp test done");

		// second reset in mid-run brings back the reset values
		reset_n <= 1'b0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		check({30'h0, stageOn}, 32'h0);
		check({30'h0, olFault}, 32'h0);
		readReg(4'h4, 2'h1, r);
		check(r, 32'h217FF7FF);
		readReg(4'h5, 2'h2, r);
		check(r, 32'h2A200000);
		readReg(4'h6, 2'h1, r);
		check(r, 32'h31000000);
		$display("reset test done");
		summarize();
	end
endmodule // solenoid_current_loop_config_regs_test
`default_nettype wire
